// File: inc/flash_host_pkg.sv
// Package for the flash status-polling host controller
package flash_host_pkg;
   // Own register map (byte addresses)
   localparam logic [3:0] reg_ctrl   = 4'h0;
   localparam logic [3:0] reg_addr   = 4'h4;
   localparam logic [3:0] reg_wdata  = 4'h8;
   localparam logic [3:0] reg_status = 4'hc;
   // Control fields
   localparam int ctrl_go_bit   = 0;
   localparam int ctrl_kind_lo  = 1;
   localparam int ctrl_word_bit = 4;
   localparam int ctrl_rst_bit  = 5;
   // Command codes written to ctrl kind field
   localparam logic [2:0] cmd_program = 3'h0;
   localparam logic [2:0] cmd_chip    = 3'h1;
   localparam logic [2:0] cmd_sector  = 3'h2;
   localparam logic [2:0] cmd_suspend = 3'h3;
   localparam logic [2:0] cmd_resume  = 3'h4;
   localparam logic [2:0] cmd_reset   = 3'h5;
   // Flash command bytes and unlock addresses
   localparam logic [7:0]  fb_aa     = 8'haa;
   localparam logic [7:0]  fb_55     = 8'h55;
   localparam logic [7:0]  fb_prog   = 8'ha0;
   localparam logic [7:0]  fb_erase  = 8'h80;
   localparam logic [7:0]  fb_chip   = 8'h10;
   localparam logic [7:0]  fb_sector = 8'h30;
   localparam logic [7:0]  fb_susp   = 8'hb0;
   localparam logic [7:0]  fb_resume = 8'h30;
   localparam logic [7:0]  fb_reset  = 8'hf0;
   localparam logic [19:0] ua_1      = 20'h00555;
   localparam logic [19:0] ua_2      = 20'h002aa;
   // Status bit positions on the data lines
   localparam int polling_pos  = 7;
   localparam int toggle_pos   = 6;
   localparam int limit_pos    = 5;
   localparam int window_pos   = 3;
   localparam int suspend_pos  = 2;
   // Bus phase timing: the write strobe low phase lasts this long, the read strobe low phase one cycle more
   localparam int clk_mhz        = 40;
   localparam int phase_ns       = 125;
   localparam int phase_cycles   = (phase_ns * clk_mhz + 999) / 1000;
   // Result codes
   localparam logic [1:0] res_busy = 2'h0;
   localparam logic [1:0] res_done = 2'h1;
   localparam logic [1:0] res_fail = 2'h2;

   typedef struct packed {
      logic        ce_n;
      logic        oe_n;
      logic        we_n;
      logic        byte_n;
      logic [19:0] addr;
   } flash_ctl_t;

   typedef enum logic [7:0] {
      st_idle  = 8'h01,
      st_wset  = 8'h02,
      st_wlow  = 8'h04,
      st_whigh = 8'h08,
      st_rlow  = 8'h10,
      st_rcmp  = 8'h20,
      st_rhigh = 8'h40,
      st_end   = 8'h80
   } host_state_t;
endpackage

// File: hw/flash_host.sv
// Host controller that sequences commands into the flash and polls its status flags
`timescale 1ns/1ps
module flash_host
   import flash_host_pkg::*;
#(
   parameter int addr_w = 20
)
(
   input  wire logic              aclk,          // 40 MHz clock
   input  wire logic              aresetn,       // Sync reset, active low
   input  wire logic [3:0]        s_axi_awaddr,  // Write address
   input  wire logic              s_axi_awvalid, // Write address valid
   output logic                   s_axi_awready, // Write address ready
   input  wire logic [31:0]       s_axi_wdata,   // Write data
   input  wire logic [3:0]        s_axi_wstrb,   // Write strobes
   input  wire logic              s_axi_wvalid,  // Write data valid
   output logic                   s_axi_wready,  // Write data ready
   output logic [1:0]             s_axi_bresp,   // Write response
   output logic                   s_axi_bvalid,  // Write response valid
   input  wire logic              s_axi_bready,  // Write response ready
   input  wire logic [3:0]        s_axi_araddr,  // Read address
   input  wire logic              s_axi_arvalid, // Read address valid
   output logic                   s_axi_arready, // Read address ready
   output logic [31:0]            s_axi_rdata,   // Read data
   output logic [1:0]             s_axi_rresp,   // Read response
   output logic                   s_axi_rvalid,  // Read data valid
   input  wire logic              s_axi_rready,  // Read data ready
   output logic                   ce_n,          // Chip select, active low
   output logic                   oe_n,          // Output enable, active low
   output logic                   we_n,          // Write strobe, active low
   output logic                   width_select,  // High selects word mode
   output logic [addr_w-1:0]      addr,          // Flash address
   output logic [15:0]            dq_out,        // Data lines driven value
   output logic [15:0]            dq_oe,         // Data lines enable, high drives
   input  wire logic [15:0]       dq_in,         // Data lines sampled value
   input  wire logic              ready_busy_n   // Open-drain ready/busy pin
);
   host_state_t      st_reg, st_next;
   logic [31:0]      ctrl_reg;
   logic [31:0]      addr_reg;
   logic [15:0]      wdata_reg;
   logic             busy_reg, fail_reg, recheck_reg;
   logic [1:0]       result_reg;
   logic [2:0]       step_reg, nsteps_reg;
   logic [2:0]       kind_reg;
   logic [7:0]       tmr_reg;
   logic             first_reg;
   logic [15:0]      prev_reg, stat_reg;
   logic [15:0]      dq_s1, dq_s2;
   logic             rb_s1, rb_s2;
   logic             aw_got, w_got;
   logic [3:0]       aw_a;
   logic [31:0]      w_d;

   // Pins sampled through two flops
   always_ff @(posedge aclk)
   begin
      dq_s1 <= dq_in;
      dq_s2 <= dq_s1;
      rb_s1 <= ready_busy_n;
      rb_s2 <= rb_s1;
   end

   // Command table: returns the address/data of write step n for a kind
   function automatic logic [35:0] seq_word(input logic [2:0] k, input logic [2:0] n,
                                            input logic [31:0] a, input logic [15:0] d);
      logic [19:0] ad;
      logic [15:0] da;
      ad = ua_1;
      da = {8'h00, fb_aa};
      case (n)
         3'h1:
         begin
            ad = ua_2;
            da = {8'h00, fb_55};
         end
         3'h2:
         begin
            da = {8'h00, (k == cmd_program) ? fb_prog : fb_erase};
         end
         3'h3:
         begin
            if (k == cmd_program)
            begin
               ad = a[19:0];
               da = d;
            end
         end
         3'h4:
         begin
            ad = ua_2;
            da = {8'h00, fb_55};
         end
         3'h5:
         begin
            ad = (k == cmd_sector) ? a[19:0] : ua_1;
            da = {8'h00, (k == cmd_sector) ? fb_sector : fb_chip};
         end
         default:
         begin
         end
      endcase
      if (k == cmd_suspend)
      begin
         ad = a[19:0];
         da = {8'h00, fb_susp};
      end
      else if (k == cmd_resume)
      begin
         ad = a[19:0];
         da = {8'h00, fb_resume};
      end
      else if (k == cmd_reset)
      begin
         ad = a[19:0];
         da = {8'h00, fb_reset};
      end
      seq_word = {ad, da};
   endfunction

   wire        go_wr    = aw_got && w_got && !s_axi_bvalid && aw_a == reg_ctrl && w_d[ctrl_go_bit];
   wire [2:0]  go_kind  = w_d[ctrl_kind_lo +: 3];
   // After failure only reset is accepted
   wire        go_ok    = !busy_reg && (!fail_reg || go_kind == cmd_reset);
   wire [35:0] cur_seq  = seq_word(kind_reg, step_reg, addr_reg, wdata_reg);
   wire        tmr_done = tmr_reg == 8'(phase_cycles - 1);
   wire        tog_same = stat_reg[toggle_pos] == prev_reg[toggle_pos];
   wire        lim_hi   = stat_reg[limit_pos];

   // AXI write side: accept address and data in either order
   assign s_axi_awready = !aw_got && !s_axi_bvalid;
   assign s_axi_wready  = !w_got && !s_axi_bvalid;
   assign s_axi_bresp   = 2'h0;
   assign s_axi_rresp   = 2'h0;
   assign s_axi_arready = !s_axi_rvalid;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_got       <= 1'b0;
         w_got        <= 1'b0;
         aw_a         <= 4'h0;
         w_d          <= 32'h0;
         s_axi_bvalid <= 1'b0;
         ctrl_reg     <= 32'h0;
         addr_reg     <= 32'h0;
         wdata_reg    <= 16'h0;
      end
      else
      begin
         if (s_axi_awvalid && s_axi_awready)
         begin
            aw_got <= 1'b1;
            aw_a   <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            w_got <= 1'b1;
            w_d   <= s_axi_wdata;
         end
         if (aw_got && w_got && !s_axi_bvalid)
         begin
            aw_got       <= 1'b0;
            w_got        <= 1'b0;
            s_axi_bvalid <= 1'b1;
            if (aw_a == reg_ctrl)
               ctrl_reg <= {w_d[31:1], 1'b0};
            else if (aw_a == reg_addr)
               addr_reg <= w_d;
            else if (aw_a == reg_wdata)
               wdata_reg <= w_d[15:0];
         end
         else if (s_axi_bvalid && s_axi_bready)
            s_axi_bvalid <= 1'b0;
      end
   end

   // AXI read side
   wire [31:0] status_word = {stat_reg, 8'h00, 3'h0, rb_s2, first_reg, fail_reg, result_reg};
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0;
      end
      else if (s_axi_arvalid && s_axi_arready)
      begin
         s_axi_rvalid <= 1'b1;
         case (s_axi_araddr)
            reg_ctrl:   s_axi_rdata <= {ctrl_reg[31:1], busy_reg};
            reg_addr:   s_axi_rdata <= addr_reg;
            reg_wdata:  s_axi_rdata <= {16'h0, wdata_reg};
            reg_status: s_axi_rdata <= status_word;
            default:    s_axi_rdata <= 32'h0;
         endcase
      end
      else if (s_axi_rvalid && s_axi_rready)
         s_axi_rvalid <= 1'b0;
   end

   // Sequencer next state
   always_comb
   begin
      st_next = st_reg;
      case (st_reg)
         st_idle:  if (go_wr && go_ok) st_next = st_wset;
         st_wset:  if (tmr_done) st_next = st_wlow;
         st_wlow:  if (tmr_done) st_next = st_whigh;
         // Polling starts only after the last strobe rises
         st_whigh: if (tmr_done) st_next = (step_reg == nsteps_reg - 3'h1) ? st_rlow : st_wset;
         st_rlow:  if (tmr_done) st_next = st_rcmp;
         st_rcmp:  st_next = st_rhigh;
         st_rhigh: if (tmr_done) st_next = st_end;
         st_end:   st_next = (result_reg == res_busy) ? st_rlow : st_idle;
         default:  st_next = st_idle;
      endcase
   end

   // Flash pins
   // Write: select and strobe low, output enable high
   // Select and output enable rise between reads
   // Command bytes occupy the low lines
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         ce_n         <= 1'b1;
         oe_n         <= 1'b1;
         we_n         <= 1'b1;
         width_select <= 1'b1;
         addr         <= '0;
         dq_out       <= 16'h0;
         dq_oe        <= 16'h0;
      end
      else
      begin
         width_select <= ctrl_reg[ctrl_word_bit];
         ce_n         <= !(st_next == st_wlow || st_next == st_rlow || st_next == st_rcmp);
         oe_n         <= !(st_next == st_rlow || st_next == st_rcmp);
         we_n         <= !(st_next == st_wlow);
         dq_oe        <= (st_next == st_wset || st_next == st_wlow || st_next == st_whigh) ? 16'hffff : 16'h0;
         addr         <= addr_w'(cur_seq[35:16]);
         dq_out       <= cur_seq[15:0];
      end
   end

   // Step, timer and status evaluation
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         st_reg      <= st_idle;
         tmr_reg     <= 8'h0;
         step_reg    <= 3'h0;
         nsteps_reg  <= 3'h0;
         kind_reg    <= cmd_program;
         busy_reg    <= 1'b0;
         fail_reg    <= 1'b0;
         recheck_reg <= 1'b0;
         result_reg  <= res_done;
         first_reg   <= 1'b1;
         prev_reg    <= 16'h0;
         stat_reg    <= 16'h0;
      end
      else
      begin
         st_reg  <= st_next;
         tmr_reg <= (st_next != st_reg || tmr_done) ? 8'h0 : tmr_reg + 8'h1;
         if (st_reg == st_idle && go_wr && go_ok)
         begin
            kind_reg   <= go_kind;
            step_reg   <= 3'h0;
            nsteps_reg <= (go_kind == cmd_program) ? 3'h4 :
                          (go_kind == cmd_chip || go_kind == cmd_sector) ? 3'h6 : 3'h1;
            busy_reg   <= 1'b1;
            result_reg <= res_busy;
            first_reg  <= 1'b1;
            recheck_reg <= 1'b0;
            if (go_kind == cmd_reset)
               fail_reg <= 1'b0;
         end
         if (st_reg == st_whigh && tmr_done)
            step_reg <= step_reg + 3'h1;
         if (st_reg == st_rcmp)
         begin
            prev_reg  <= stat_reg;
            stat_reg  <= dq_s2;
         end
         if (st_reg == st_end)
         begin
            first_reg <= 1'b0;
            if (!first_reg)
            begin
               if (tog_same)
                  result_reg <= res_done;
               // Limit high: one more check then fail
               else if (lim_hi && recheck_reg)
               begin
                  result_reg <= res_fail;
                  fail_reg   <= 1'b1;
               end
               else if (lim_hi)
                  recheck_reg <= 1'b1;
            end
            // Pin state reported, not used to end
            if (st_next == st_idle)
               busy_reg <= 1'b0;
         end
      end
   end
endmodule

// File: sim/flash_host_properties.sv
// Concurrent checks on the flash host controller's pins and register bus
`timescale 1ns/1ps
module flash_host_properties
#(
   parameter int addr_w = 20
)
(
   input wire logic              aclk,          // Clock
   input wire logic              aresetn,       // Sync reset, active low
   input wire logic              ce_n,          // Chip select
   input wire logic              oe_n,          // Output enable
   input wire logic              we_n,          // Write strobe
   input wire logic [addr_w-1:0] addr,          // Flash address
   input wire logic [15:0]       dq_out,        // Driven data
   input wire logic [15:0]       dq_oe,         // Data drive enable
   input wire logic              s_axi_arvalid, // Read address valid
   input wire logic              s_axi_arready, // Read address ready
   input wire logic              s_axi_rvalid,  // Read data valid
   input wire logic              s_axi_rready,  // Read data ready
   input wire logic [31:0]       s_axi_rdata    // Read data
);
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   a_write_oe_high: assert property (!we_n |-> !ce_n && oe_n)
      else $error("write strobe low outside a qualified write");
   a_read_no_drive: assert property (!oe_n |-> dq_oe == 16'h0 && we_n)
      else $error("host drives data lines during a read");
   a_cmd_lines_driven: assert property (!we_n |-> dq_oe == 16'hffff)
      else $error("data lines not driven during a write");
   a_strobe_width: assert property ($fell(we_n) |-> !we_n [*4])
      else $error("write strobe low phase too short");
   a_read_pulse: assert property ($fell(oe_n) |-> !ce_n [*4] ##[1:20] oe_n)
      else $error("status read not framed by chip select and released");
   a_write_hold: assert property (!we_n && $past(we_n) == 1'b0 |-> $stable(addr) && $stable(dq_out))
      else $error("address or data moved while strobe low");
   a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read answer late");
   a_rvalid_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read answer withdrawn before taken");
endmodule

bind flash_host flash_host_properties #(.addr_w(addr_w)) u_props (.aclk, .aresetn, .ce_n, .oe_n, .we_n, .addr,
   .dq_out, .dq_oe, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata);

// File: sim/flash_model.sv
// Behavioural flash device answering command writes and status reads
`timescale 1ns/1ps
module flash_model
   import flash_host_pkg::*;
#(
   parameter int busy_ns  = 3000,
   parameter int prot_bit = 19
)
(
   input  wire logic        ce_n,         // Chip select
   input  wire logic        oe_n,         // Output enable
   input  wire logic        we_n,         // Write strobe
   input  wire logic        width_select, // High selects word mode
   input  wire logic [19:0] addr,         // Address lines
   input  wire logic [15:0] dq_w,         // Host data
   input  wire logic        fail_mode,    // Next run exceeds its limit
   output logic      [15:0] q,            // Device data
   output logic      [15:0] q_en,         // Lines the device drives
   output logic             rb_low,       // Ready/busy pulled low
   output logic      [15:0] mem_word      // Last word left in the array
);
   logic        busy = 1'b0, tog = 1'b0, t2 = 1'b0, lim = 1'b0, erase = 1'b0, prot = 1'b0;
   logic [7:0]  b3 = 8'h0;
   logic [15:0] pd = 16'h0;
   int          wr = 0;
   event        go;
   // Unknown pins before reset must not look like a write or read edge
   wire         wact = (ce_n === 1'b0) && (we_n === 1'b0) && (oe_n === 1'b1);
   wire         ract = (ce_n === 1'b0) && (oe_n === 1'b0);
   initial mem_word = 16'h0;
   assign rb_low = busy;
   assign q_en = ract ? (width_select ? 16'hffff : 16'h00ff) : 16'h0;
   assign q = busy ? {8'h0, erase ? 1'b0 : ~pd[7], tog, lim, 1'b0, erase, erase ? t2 : 1'b1, 2'b0} : mem_word;
   always @(posedge ract)
      if (busy)
      begin
         tog = ~tog;
         t2 = t2 ^ erase;
      end
   always @(negedge wact)
      if (dq_w[7:0] == fb_reset)
      begin
         busy = 1'b0;
         lim = 1'b0;
         wr = 0;
      end
      else if (!busy)
      begin
         wr++;
         if (wr <= 2 && dq_w[7:0] != (wr == 1 ? fb_aa : fb_55))
            wr = 0;
         else if (wr == 3)
            b3 = dq_w[7:0];
         else if ((wr == 4 && b3 == fb_prog) || (wr == 6 && b3 == fb_erase))
         begin
            erase = wr == 6;
            prot = addr[prot_bit];
            pd = dq_w;
            wr = 0;
            ->go;
         end
      end
   always @(go)
   begin
      busy = 1'b1;
      #(prot ? (erase ? 100000 : 2000) : busy_ns);
      if (fail_mode && !prot)
         lim = 1'b1;
      else
      begin
         busy = 1'b0;
         if (!prot)
            mem_word = erase ? 16'hffff : pd;
      end
   end
endmodule

// File: sim/testbench.sv
// Self-checking bench for the flash status-polling host controller
`timescale 1ns/1ps
module testbench;
   import flash_host_pkg::*;
   logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, ce_n, oe_n, we_n, width_select;
   logic        ready_busy_n, rb_low, fail_mode;
   logic        wact_q = 1'b0;
   logic [3:0]  s_axi_awaddr, s_axi_wstrb, s_axi_araddr;
   logic [1:0]  s_axi_bresp, s_axi_rresp, rr;
   logic [31:0] s_axi_wdata, s_axi_rdata, st, d;
   logic [19:0] addr;
   logic [15:0] dq_out, dq_oe, dq_in, m_q, m_en, mem_word;
   logic [15:0] dq_last = 16'h0;
   logic [31:0] seed = 32'h78a1e2a2;
   int          mismatches, check_count, wr_cnt, mem_exp;
   int          kinds[6] = '{cmd_program, cmd_chip, cmd_program, cmd_sector, cmd_program, cmd_sector};
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin mismatches++; \
   $display("[FAIL] t=%0t got %h exp %h", $time, a, b); end end

   flash_host #(.addr_w(20)) dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
      .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .ce_n, .oe_n,
      .we_n, .width_select, .addr, .dq_out, .dq_oe, .dq_in, .ready_busy_n);
   flash_model #(.busy_ns(3000), .prot_bit(19)) dev (.ce_n, .oe_n, .we_n, .width_select, .addr, .dq_w(dq_out),
      .fail_mode, .q(m_q), .q_en(m_en), .rb_low, .mem_word);

   // Pull-up on ready/busy; released data lines drift so a stale value cannot pass
   assign ready_busy_n = rb_low ? 1'b0 : 1'b1;
   assign dq_in = (m_en & m_q) | (~m_en & dq_oe & dq_out) | (~m_en & ~dq_oe & ~dq_last);
   always #12.5 aclk = ~aclk;
   always @(posedge aclk)
   begin
      dq_last <= dq_in;
      wact_q <= !ce_n && !we_n && oe_n;
      if (wact_q && !(!ce_n && !we_n && oe_n))
         wr_cnt++;
   end

   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction

   // Bus waits carry no limit of their own; only the watchdog ends a hung transfer
   task automatic axi_wr(input logic [3:0] a, input logic [31:0] v);
      begin
         @(posedge aclk);
         s_axi_awaddr <= a;
         s_axi_wdata <= v;
         s_axi_awvalid <= 1'b1;
         s_axi_wvalid <= 1'b1;
         s_axi_bready <= 1'b1;
         do
         begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
         end while (s_axi_bvalid !== 1'b1);
         s_axi_bready <= 1'b0;
      end
   endtask

   task automatic axi_rd(input logic [3:0] a, output logic [31:0] v);
      begin
         @(posedge aclk);
         s_axi_araddr <= a;
         s_axi_arvalid <= 1'b1;
         s_axi_rready <= 1'b1;
         do
         begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
         end while (s_axi_rvalid !== 1'b1);
         v = s_axi_rdata;
         rr = s_axi_rresp;
         s_axi_rready <= 1'b0;
      end
   endtask

   task automatic op(input int k, input logic word, input logic [1:0] res, input int nw);
      int n;
      logic [31:0] c;
      begin
         wr_cnt = 0;
         axi_wr(reg_ctrl, 32'(1 + (k << ctrl_kind_lo) + (int'(word) << ctrl_word_bit)));
         n = 0;
         do
         begin
            axi_rd(reg_status, st);
            n++;
         end while (st[1:0] === res_busy && n < 3000);
         // Result shows before the final read ends; a go is refused until idle
         do
         begin
            axi_rd(reg_ctrl, c);
         end while (c[0] !== 1'b0);
         `CHK(st[1:0], res)
         `CHK(wr_cnt, nw)
         `CHK(width_select, word)
         `CHK(st[4], res != res_fail)
         `CHK(st[3], 1'b0)
         if (res == res_fail)
            `CHK(st[2], 1'b1)
         $display("test kind %0d ended, result %0d", k, st[1:0]);
      end
   endtask

   task automatic end_of_test();
      begin
         $display("checks %0d, mismatches %0d", check_count, mismatches);
         if (mismatches == 0 && check_count > 0)
            $display("RESULT: PASS");
         else
            $display("RESULT: FAIL");
         $finish;
      end
   endtask

   initial
   begin
      repeat (90000) @(posedge aclk);
      mismatches++;
      end_of_test();
   end

   initial
   begin
      aclk = 1'b0;
      aresetn = 1'b0;
      fail_mode = 1'b0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = {8'h0, 32'h0, 4'hf};
      repeat (8) @(posedge aclk);
      aresetn <= 1'b1;
      axi_rd(4'h2, d);
      `CHK(rr, 2'h0)
      `CHK({ce_n, oe_n, we_n}, 3'h7)
      mem_exp = 0;
      // Good and protected program and erase runs
      foreach (kinds[i])
      begin
         d = rnd();
         axi_wr(reg_addr, {12'h0, i >= 4, d[30:12]});
         axi_wr(reg_wdata, d);
         op(kinds[i], kinds[i] == cmd_program, res_done, kinds[i] == cmd_program ? 4 : 6);
         if (i < 4)
            mem_exp = (kinds[i] == cmd_program) ? int'(d[15:0]) : 32'hffff;
         `CHK(mem_word, mem_exp[15:0])
         `CHK(st[23:16], mem_exp[7:0])
      end
      op(cmd_suspend, 1'b1, res_done, 1);
      op(cmd_resume, 1'b1, res_done, 1);
      // Failure, refused restart, then recovery by reset command
      fail_mode <= 1'b1;
      axi_wr(reg_addr, 32'h100);
      op(cmd_program, 1'b1, res_fail, 4);
      op(cmd_program, 1'b1, res_fail, 0);
      fail_mode <= 1'b0;
      op(cmd_reset, 1'b1, res_done, 1);
      end_of_test();
   end
endmodule
